// [hw/fstr_pkg.sv]
package fstr_pkg;

   //---------------------------------------------------------------
   // widths
   //---------------------------------------------------------------
   localparam int COUNT_W = 11;
   localparam int POS_W = 10;
   localparam int TIME_W = 24;
   localparam int WORD_W = 16;
   localparam int TICK_W = 16;

   //---------------------------------------------------------------
   // register offsets
   //---------------------------------------------------------------
   localparam logic [6:0] OFS_EXT_BYTE9 = 7'h36;
   localparam logic [6:0] OFS_EXT_BYTE10 = 7'h37;
   localparam logic [6:0] OFS_EXT_BYTE11 = 7'h38;
   localparam logic [6:0] OFS_EXT_BYTE12 = 7'h39;
   localparam logic [6:0] OFS_LEVEL_LOW = 7'h3a;
   localparam logic [6:0] OFS_LEVEL_HIGH = 7'h3b;
   localparam logic [6:0] OFS_POS_LOW = 7'h3c;
   localparam logic [6:0] OFS_POS_HIGH = 7'h3d;
   localparam logic [6:0] OFS_OUT_FIRST = 7'h3e;
   localparam logic [6:0] OFS_OUT_SECOND = 7'h3f;
   localparam logic [6:0] OFS_TIME_BYTE0 = 7'h40;
   localparam logic [6:0] OFS_TIME_BYTE1 = 7'h41;
   localparam logic [6:0] OFS_TIME_BYTE2 = 7'h42;

   //---------------------------------------------------------------
   // fields, codes, reset values, timing
   //---------------------------------------------------------------
   localparam int MARK_BIT = 7;
   localparam int OVERRUN_BIT = 6;
   localparam int FULL_BIT = 5;
   localparam int EMPTY_BIT = 4;
   localparam logic [7:0] TIME_RESET_CODE = 8'haa;
   localparam logic [7:0] READ_IDLE = 8'h00;
   localparam logic [COUNT_W-1:0] MAX_COUNT = 11'h7ff;
   localparam int TICK_FINE_CYC = 1000;
   localparam int TICK_COARSE_CYC = 4000;

   //---------------------------------------------------------------
   // carriers
   //---------------------------------------------------------------
   typedef struct packed {
      logic rd;
      logic wr;
      logic [6:0] addr;
      logic [7:0] wdata;
   } fstr_reg_req_t;

   typedef struct packed {
      logic valid;
      logic [WORD_W-1:0] word;
   } fstr_push_t;

   typedef struct packed {
      logic [7:0] posHigh;
      logic [7:0] posLow;
      logic [7:0] levelHigh;
      logic [7:0] levelLow;
   } fstr_status_t;

endpackage : fstr_pkg

// [hw/fstr_readout.sv]
`timescale 1ns/1ns
`default_nettype none
module fstr_readout #(
   parameter int TICK_FINE_CYC = fstr_pkg::TICK_FINE_CYC,
   parameter int TICK_COARSE_CYC = fstr_pkg::TICK_COARSE_CYC
) (
   input wire logic clk, // 100 MHz sample clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic ce, // clock enable, freezes all state when low
   input wire fstr_pkg::fstr_reg_req_t regReq, // register read/write request
   output logic [7:0] rdData, // read answer byte
   output logic rdValid, // one-cycle pulse with rdData
   input wire logic [31:0] extSensorBytes, // bytes 9..12, byte 9 in 7:0
   input wire fstr_pkg::fstr_push_t push, // word from the write side
   output logic pushReady, // queue can take a word
   input wire logic [10:0] queueThreshold, // threshold level in words
   input wire logic [9:0] patternLength, // words in one sample pattern
   input wire logic blockUpdateHold, // block update hold setting
   input wire logic stampCoarse, // time resolution select
   output logic thresholdReached // threshold flag
);

   //---------------------------------------------------------------
   // declarations
   //---------------------------------------------------------------
   localparam int DEPTH = 2 ** fstr_pkg::COUNT_W;

   logic [fstr_pkg::WORD_W-1:0] queueMem [DEPTH];
   logic [fstr_pkg::COUNT_W-1:0] wrPtr_reg;
   logic [fstr_pkg::COUNT_W-1:0] rdPtr_reg;
   logic [fstr_pkg::COUNT_W-1:0] count_reg;
   logic [fstr_pkg::COUNT_W-1:0] count_next;
   logic [fstr_pkg::POS_W-1:0] pos_reg;
   logic [fstr_pkg::POS_W-1:0] pos_next;
   logic lowSeen_reg;
   logic overrun_reg;
   logic thrFlag_reg;
   logic pushReady_reg;
   logic [fstr_pkg::TIME_W-1:0] timeCount_reg;
   logic [fstr_pkg::TICK_W-1:0] tick_reg;
   logic [fstr_pkg::TICK_W-1:0] tickLimit;
   logic [fstr_pkg::TIME_W-1:0] timeSnap_reg;
   logic timeLocked_reg;
   fstr_pkg::fstr_status_t statusLive;
   fstr_pkg::fstr_status_t statusSnap_reg;
   logic statusLocked_reg;
   logic [7:0] rdData_reg;
   logic rdValid_reg;
   logic [7:0] readMux;
   logic [fstr_pkg::WORD_W-1:0] headWord;
   logic [fstr_pkg::TIME_W-1:0] timeView;
   fstr_pkg::fstr_status_t statusView;
   logic reqRd;
   logic reqWr;
   logic popNow;
   logic pushAccept;
   logic queueEmpty;
   logic timeClear;
   logic tickWrap;

   //---------------------------------------------------------------
   // request decode
   //---------------------------------------------------------------
   // reads and writes only count while the clock enable is high
   assign reqRd = ce && regReq.rd;
   assign reqWr = ce && regReq.wr;
   assign queueEmpty = (count_reg == '0);
   assign headWord = queueMem[rdPtr_reg];
   // the word leaves only after its first byte was read, then its second
   assign popNow = reqRd && (regReq.addr == fstr_pkg::OFS_OUT_SECOND)
      && lowSeen_reg && !queueEmpty;
   assign pushAccept = ce && push.valid && (count_reg != fstr_pkg::MAX_COUNT);
   // only the reset code has an effect on the top time byte
   assign timeClear = reqWr && (regReq.addr == fstr_pkg::OFS_TIME_BYTE2)
      && (regReq.wdata == fstr_pkg::TIME_RESET_CODE);

   //---------------------------------------------------------------
   // queue occupancy and pattern position
   //---------------------------------------------------------------
   // next count and next pattern position
   always_comb begin
      count_next = count_reg;
      if (pushAccept && !popNow) begin
         count_next = count_reg + 11'h001;
      end else if (popNow && !pushAccept) begin
         count_next = count_reg - 11'h001;
      end
      pos_next = pos_reg;
      if (popNow) begin
         if ((pos_reg + 10'h001) >= patternLength) begin
            pos_next = '0;
         end else begin
            pos_next = pos_reg + 10'h001;
         end
      end
   end

   // queue storage, write side only
   always_ff @(posedge clk) begin
      if (pushAccept) begin
         queueMem[wrPtr_reg] <= push.word;
      end
   end

   // pointers, count and position
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
         pos_reg <= '0;
      end else if (ce) begin
         if (pushAccept) begin
            wrPtr_reg <= wrPtr_reg + 11'h001;
         end
         if (popNow) begin
            rdPtr_reg <= rdPtr_reg + 11'h001;
         end
         count_reg <= count_next;
         pos_reg <= pos_next;
      end
   end

   // first-byte-seen marker for the two-byte pop
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lowSeen_reg <= 1'b0;
      end else if (reqRd && !queueEmpty && regReq.addr == fstr_pkg::OFS_OUT_FIRST) begin
         lowSeen_reg <= 1'b1;
      end else if (popNow) begin
         lowSeen_reg <= 1'b0;
      end
   end

   // overrun is sticky; a lost word in the cycle of a pop still sets it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         overrun_reg <= 1'b0;
      end else if (ce && push.valid && !pushAccept) begin
         overrun_reg <= 1'b1;
      end else if (popNow) begin
         overrun_reg <= 1'b0;
      end
   end

   // threshold flag and push ready follow the next occupancy
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         thrFlag_reg <= 1'b0;
         pushReady_reg <= 1'b1;
      end else if (ce) begin
         thrFlag_reg <= (count_next >= queueThreshold);
         pushReady_reg <= (count_next != fstr_pkg::MAX_COUNT);
      end
   end

   //---------------------------------------------------------------
   // time count
   //---------------------------------------------------------------
   // tick period picked by the time resolution select
   assign tickLimit = stampCoarse ? fstr_pkg::TICK_W'(TICK_COARSE_CYC - 1)
                                  : fstr_pkg::TICK_W'(TICK_FINE_CYC - 1);
   assign tickWrap = (tick_reg >= tickLimit);

   // prescaler and 24-bit counter, cleared by the reset code
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tick_reg <= '0;
         timeCount_reg <= '0;
      end else if (ce) begin
         if (timeClear) begin
            tick_reg <= '0;
            timeCount_reg <= '0;
         end else if (tickWrap) begin
            tick_reg <= '0;
            timeCount_reg <= timeCount_reg + 24'h000001;
         end else begin
            tick_reg <= tick_reg + 16'h0001;
         end
      end
   end

   //---------------------------------------------------------------
   // block update hold snapshots
   //---------------------------------------------------------------
   // live status bytes
   always_comb begin
      statusLive.levelLow = count_reg[7:0];
      statusLive.levelHigh = {thrFlag_reg, overrun_reg,
         count_reg == fstr_pkg::MAX_COUNT, queueEmpty, 1'b0, count_reg[10:8]};
      statusLive.posLow = pos_reg[7:0];
      statusLive.posHigh = {6'h00, pos_reg[9:8]};
   end

   // under hold the first byte read freezes the group until its last byte
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         statusLocked_reg <= 1'b0;
         statusSnap_reg <= '0;
      end else if (ce) begin
         if (!blockUpdateHold) begin
            statusLocked_reg <= 1'b0;
         end else if (reqRd && regReq.addr == fstr_pkg::OFS_LEVEL_LOW) begin
            statusLocked_reg <= 1'b1;
            statusSnap_reg <= statusLive;
         end else if (reqRd && regReq.addr == fstr_pkg::OFS_POS_HIGH) begin
            statusLocked_reg <= 1'b0;
         end
      end
   end

   // same scheme for the three time bytes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         timeLocked_reg <= 1'b0;
         timeSnap_reg <= '0;
      end else if (ce) begin
         if (!blockUpdateHold || timeClear) begin
            timeLocked_reg <= 1'b0;
         end else if (reqRd && regReq.addr == fstr_pkg::OFS_TIME_BYTE0) begin
            timeLocked_reg <= 1'b1;
            timeSnap_reg <= timeCount_reg;
         end else if (reqRd && regReq.addr == fstr_pkg::OFS_TIME_BYTE2) begin
            timeLocked_reg <= 1'b0;
         end
      end
   end

   assign statusView = statusLocked_reg ? statusSnap_reg : statusLive;
   assign timeView = timeLocked_reg ? timeSnap_reg : timeCount_reg;

   //---------------------------------------------------------------
   // read answer
   //---------------------------------------------------------------
   // byte selected by the offset; unmapped offsets read zero
   always_comb begin
      case (regReq.addr)
         fstr_pkg::OFS_EXT_BYTE9: readMux = extSensorBytes[7:0];
         fstr_pkg::OFS_EXT_BYTE10: readMux = extSensorBytes[15:8];
         fstr_pkg::OFS_EXT_BYTE11: readMux = extSensorBytes[23:16];
         fstr_pkg::OFS_EXT_BYTE12: readMux = extSensorBytes[31:24];
         fstr_pkg::OFS_LEVEL_LOW: readMux = statusView.levelLow;
         fstr_pkg::OFS_LEVEL_HIGH: readMux = statusView.levelHigh;
         fstr_pkg::OFS_POS_LOW: readMux = statusView.posLow;
         fstr_pkg::OFS_POS_HIGH: readMux = statusView.posHigh;
         fstr_pkg::OFS_OUT_FIRST: readMux = queueEmpty ? 8'h00 : headWord[7:0];
         fstr_pkg::OFS_OUT_SECOND: readMux = queueEmpty ? 8'h00 : headWord[15:8];
         fstr_pkg::OFS_TIME_BYTE0: readMux = timeView[7:0];
         fstr_pkg::OFS_TIME_BYTE1: readMux = timeView[15:8];
         fstr_pkg::OFS_TIME_BYTE2: readMux = timeView[23:16];
         default: readMux = fstr_pkg::READ_IDLE;
      endcase
   end

   // answer register, data held until the next read
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdData_reg <= fstr_pkg::READ_IDLE;
         rdValid_reg <= 1'b0;
      end else if (ce) begin
         rdValid_reg <= regReq.rd;
         if (regReq.rd) begin
            rdData_reg <= readMux;
         end
      end
   end

   assign rdData = rdData_reg;
   assign rdValid = rdValid_reg;
   assign pushReady = pushReady_reg;
   assign thresholdReached = thrFlag_reg;

   //---------------------------------------------------------------
   // assertions
   //---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_sensor_byte: assert property (reqRd && regReq.addr == fstr_pkg::OFS_EXT_BYTE11
      |=> rdValid && rdData == $past(extSensorBytes[23:16]))
      else $error("external sensor byte read wrong");

   a_level_low: assert property (reqRd && !statusLocked_reg
      && regReq.addr == fstr_pkg::OFS_LEVEL_LOW
      |=> rdData == $past(count_reg[7:0]))
      else $error("level low byte wrong");

   a_level_high: assert property (reqRd && !statusLocked_reg
      && regReq.addr == fstr_pkg::OFS_LEVEL_HIGH
      |=> rdData[3:0] == {1'b0, $past(count_reg[10:8])})
      else $error("level high bits wrong");

   a_mark_flag: assert property (ce
      |=> thrFlag_reg == (count_reg >= $past(queueThreshold)))
      else $error("threshold flag does not follow level");

   a_pattern_high: assert property (reqRd && regReq.addr == fstr_pkg::OFS_POS_HIGH
      |=> rdData[7:2] == 6'h00)
      else $error("pattern high unused bits not zero");

   a_data_bytes: assert property (reqRd && !queueEmpty
      && regReq.addr == fstr_pkg::OFS_OUT_FIRST
      |=> rdData == $past(headWord[7:0]))
      else $error("first data byte wrong");

   a_stamp_byte: assert property (reqRd && !timeLocked_reg
      && regReq.addr == fstr_pkg::OFS_TIME_BYTE1
      |=> rdData == $past(timeCount_reg[15:8]))
      else $error("time byte read wrong");

   a_stamp_tick: assert property (ce && !timeClear && tickWrap
      |=> timeCount_reg == $past(timeCount_reg) + 24'h000001 && tick_reg == '0)
      else $error("time count did not step at tick");

   a_stamp_clear: assert property (timeClear |=> timeCount_reg == '0)
      else $error("reset code did not clear time count");

   a_stamp_ro: assert property (reqWr && !timeClear && !tickWrap
      |=> timeCount_reg == $past(timeCount_reg))
      else $error("write altered time count");

   a_pop_update: assert property (popNow && !pushAccept
      |=> count_reg == $past(count_reg) - 11'h001 && !lowSeen_reg)
      else $error("pop did not lower count");

   a_pattern_wrap: assert property (popNow && (pos_reg + 10'h001) >= patternLength
      |=> pos_reg == '0)
      else $error("pattern position did not wrap");

   a_empty_flag: assert property (reqRd && !statusLocked_reg
      && regReq.addr == fstr_pkg::OFS_LEVEL_HIGH
      |=> rdData[fstr_pkg::EMPTY_BIT] == ($past(count_reg) == '0))
      else $error("empty flag wrong");

   a_overrun_sticky: assert property (ce && push.valid && !pushAccept |=> overrun_reg)
      else $error("refused word did not set overrun");

   c_word_popped: cover property (popNow);
   c_time_cleared: cover property (timeClear);
   c_pattern_wrap: cover property (popNow && pos_next == '0);
   c_mark_rise: cover property (!thrFlag_reg ##1 thrFlag_reg);
   c_queue_full: cover property (count_reg == fstr_pkg::MAX_COUNT);

endmodule : fstr_readout
`default_nettype wire

// [tb/fstr_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// host side of the register bus
// ---------------------------------------------------------------
module fstr_host_model (
   input wire logic clk, // sample clock
   output var fstr_pkg::fstr_reg_req_t regReq, // register request
   output var logic blockUpdateHold, // hold setting seen by the block
   input wire logic [7:0] rdData, // answer byte
   input wire logic rdValid // answer strobe
);
   // bus idle and hold off from time zero
   initial begin
      regReq = '0;
      blockUpdateHold = 1'b0;
   end

   // one-cycle read pulse, answer taken in the cycle after it
   task automatic readReg(input logic [6:0] addr, output logic [7:0] data, output logic ok);
      @(posedge clk);
      regReq <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
      @(posedge clk);
      regReq <= '0;
      @(negedge clk);
      ok = rdValid;
      data = rdData;
   endtask : readReg

   // one-cycle write pulse; the clear code goes to the top time byte
   task automatic writeReg(input logic [6:0] addr, input logic [7:0] data);
      @(posedge clk);
      regReq <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
      @(posedge clk);
      regReq <= '0;
   endtask : writeReg

   // hold is raised before multi-byte reads so the bytes agree
   task automatic setHold(input logic v);
      @(posedge clk);
      blockUpdateHold <= v;
   endtask : setHold
endmodule : fstr_host_model
`default_nettype wire

// [tb/test_fstr_readout.sv]
`timescale 1ns/1ns
`default_nettype none
module test_fstr_readout;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic clk;
   logic rst_n;
   logic ce;
   fstr_pkg::fstr_reg_req_t regReq;
   logic [7:0] rdData;
   logic rdValid;
   logic [31:0] extSensorBytes;
   fstr_pkg::fstr_push_t push;
   logic pushReady;
   logic [10:0] queueThreshold;
   logic [9:0] patternLength;
   logic blockUpdateHold;
   logic stampCoarse;
   logic thresholdReached;
   int errTotal = 0;
   int comparisons = 0;
   int cycles = 0;

   // ---------------------------------------------------------------
   // design and host
   // ---------------------------------------------------------------
   fstr_readout #(.TICK_FINE_CYC(4), .TICK_COARSE_CYC(8)) i_fstr_readout (
      .clk(clk), .rst_n(rst_n), .ce(ce), .regReq(regReq), .rdData(rdData),
      .rdValid(rdValid), .extSensorBytes(extSensorBytes), .push(push),
      .pushReady(pushReady), .queueThreshold(queueThreshold),
      .patternLength(patternLength), .blockUpdateHold(blockUpdateHold),
      .stampCoarse(stampCoarse), .thresholdReached(thresholdReached));
   fstr_host_model i_fstr_host_model (
      .clk(clk), .regReq(regReq), .blockUpdateHold(blockUpdateHold),
      .rdData(rdData), .rdValid(rdValid));

   // clock and cycle ceiling
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errTotal++;
         printVerdict();
      end
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errTotal++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // read one byte and compare it, answer strobe included
   task automatic checkReg(input logic [6:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      i_fstr_host_model.readReg(addr, d, ok);
      check("answer strobe", 1, ok);
      check($sformatf("offset %h", addr), exp, d);
   endtask : checkReg

   task automatic readTime(output logic [23:0] t);
      logic ok;
      i_fstr_host_model.setHold(1'b1);
      i_fstr_host_model.readReg(fstr_pkg::OFS_TIME_BYTE0, t[7:0], ok);
      i_fstr_host_model.readReg(fstr_pkg::OFS_TIME_BYTE1, t[15:8], ok);
      i_fstr_host_model.readReg(fstr_pkg::OFS_TIME_BYTE2, t[23:16], ok);
      i_fstr_host_model.setHold(1'b0);
   endtask : readTime

   task automatic doReset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
   endtask : doReset

   task automatic pushWords(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         push <= '{valid: 1'b1, word: {8'h10 + 8'(i), 8'h80 + 8'(i)}};
      end
      @(posedge clk);
      push <= '0;
   endtask : pushWords

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic scenEmptyAndSensors();
      logic [7:0] d;
      logic ok;
      checkReg(fstr_pkg::OFS_LEVEL_LOW, 8'h00);
      checkReg(fstr_pkg::OFS_LEVEL_HIGH, 8'h10);
      checkReg(fstr_pkg::OFS_OUT_FIRST, 8'h00);
      for (int i = 0; i < 4; i++) begin
         checkReg(fstr_pkg::OFS_EXT_BYTE9 + 7'(i), extSensorBytes[8*i +: 8]);
      end
      checkReg(7'h35, fstr_pkg::READ_IDLE);
      @(posedge clk);
      ce <= 1'b0;
      i_fstr_host_model.readReg(fstr_pkg::OFS_LEVEL_LOW, d, ok);
      check("strobe while frozen", 0, ok);
      @(posedge clk);
      ce <= 1'b1;
   endtask : scenEmptyAndSensors

   task automatic scenPushPop();
      pushWords(5);
      checkReg(fstr_pkg::OFS_LEVEL_LOW, 8'h05);
      checkReg(fstr_pkg::OFS_LEVEL_HIGH, 8'h80);
      check("threshold flag", 1, thresholdReached);
      for (int i = 0; i < 5; i++) begin
         checkReg(fstr_pkg::OFS_OUT_FIRST, 8'h80 + 8'(i));
         checkReg(fstr_pkg::OFS_OUT_SECOND, 8'h10 + 8'(i));
         checkReg(fstr_pkg::OFS_POS_LOW, 8'((i + 1) % 3));
         checkReg(fstr_pkg::OFS_LEVEL_LOW, 8'(4 - i));
      end
      checkReg(fstr_pkg::OFS_POS_HIGH, 8'h00);
      checkReg(fstr_pkg::OFS_LEVEL_HIGH, 8'h10);
      check("threshold flag", 0, thresholdReached);
      // under hold the status group keeps the level seen at the first byte
      i_fstr_host_model.setHold(1'b1);
      checkReg(fstr_pkg::OFS_LEVEL_LOW, 8'h00);
      pushWords(2);
      checkReg(fstr_pkg::OFS_LEVEL_HIGH, 8'h10);
      checkReg(fstr_pkg::OFS_POS_HIGH, 8'h00);
      checkReg(fstr_pkg::OFS_LEVEL_LOW, 8'h02);
      i_fstr_host_model.setHold(1'b0);
      doReset();
   endtask : scenPushPop

   task automatic scenFull();
      pushWords(2048);
      @(negedge clk);
      check("push ready", 0, pushReady);
      checkReg(fstr_pkg::OFS_LEVEL_LOW, 8'hff);
      checkReg(fstr_pkg::OFS_LEVEL_HIGH, 8'he7);
      checkReg(fstr_pkg::OFS_OUT_FIRST, 8'h80);
      checkReg(fstr_pkg::OFS_OUT_SECOND, 8'h10);
      checkReg(fstr_pkg::OFS_LEVEL_LOW, 8'hfe);
      checkReg(fstr_pkg::OFS_LEVEL_HIGH, 8'h87);
      check("push ready", 1, pushReady);
      doReset();
   endtask : scenFull

   task automatic scenTime();
      logic [23:0] t;
      logic [23:0] prev;
      i_fstr_host_model.writeReg(fstr_pkg::OFS_TIME_BYTE2, fstr_pkg::TIME_RESET_CODE);
      readTime(t);
      check("time just cleared", 1, t < 24'd4);
      i_fstr_host_model.writeReg(fstr_pkg::OFS_TIME_BYTE2, 8'haa);
      repeat (400) @(posedge clk);
      readTime(t);
      check("fine tick count", 1, t >= 24'd99 && t <= 24'd103);
      prev = t;
      i_fstr_host_model.writeReg(fstr_pkg::OFS_TIME_BYTE2, 8'h55);
      i_fstr_host_model.writeReg(fstr_pkg::OFS_TIME_BYTE0, 8'haa);
      i_fstr_host_model.writeReg(fstr_pkg::OFS_TIME_BYTE1, 8'haa);
      readTime(t);
      check("time kept running", 1, t > prev && t[23:16] == 8'h00);
      @(posedge clk);
      stampCoarse <= 1'b1;
      i_fstr_host_model.writeReg(fstr_pkg::OFS_TIME_BYTE2, 8'haa);
      repeat (400) @(posedge clk);
      readTime(t);
      check("coarse tick count", 1, t >= 24'd49 && t <= 24'd52);
   endtask : scenTime

   // ---------------------------------------------------------------
   // verdict
   // ---------------------------------------------------------------
   task automatic printVerdict();
      $display("comparisons %0d errors %0d", comparisons, errTotal);
      if (errTotal == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : printVerdict

   // main sequence
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      extSensorBytes = 32'h44332211;
      push = '0;
      queueThreshold = 11'h004;
      patternLength = 10'h003;
      stampCoarse = 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      scenEmptyAndSensors();
      scenPushPop();
      scenFull();
      scenTime();
      printVerdict();
   end
endmodule : test_fstr_readout
`default_nettype wire
